// file: src/fcs_host.sv
/*
  Host-side controller for a boot-block flash: software orders program,
  erase, suspend, resume, array and status reads through a small register
  port; the controller sequences the flash command writes and polls.
  Assumes the flash pins are wired straight to the device.
*/
// Added by the designer: the register addresses and the plain strobed port.
module fcs_host #(
  parameter int ADDR_W    = 17,
  parameter int BLK_SHIFT = 12
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       nrst_i,
  input  wire logic [fcs_pkg::REG_AW-1:0] reg_addr_i,
  input  wire logic [fcs_pkg::REG_DW-1:0] reg_wdata_i,
  input  wire logic                       reg_we_i,
  input  wire logic                       reg_re_i,
  output logic [fcs_pkg::REG_DW-1:0]      reg_rdata_o,
  output logic                            ce_n_o,
  output logic                            oe_n_o,
  output logic                            we_n_o,
  output logic [ADDR_W-1:0]               addr_o,
  input  wire logic [fcs_pkg::DQ_W-1:0]   dq_i,
  output logic [fcs_pkg::DQ_W-1:0]        dq_o,
  output logic                            dq_oe_o,
  output logic                            wp_n_o,
  output logic                            rp_n_o,
  output logic                            byte_n_o
);
  import fcs_pkg::*;

  if (ADDR_W > REG_DW || BLK_SHIFT >= ADDR_W || BLK_SHIFT < 1)
  begin : g_bad
    $error("fcs_host: address or block width cannot be served");
  end

  typedef enum logic [3:0] {
    S_IDLE, S_CLR, S_SETUP, S_ARG, S_RSTAT, S_POLL,
    S_SUSP, S_RESUME, S_RARR, S_RDATA
  } fcs_st_e;

  function automatic logic same_block(input logic [ADDR_W-1:0] a,
                                      input logic [ADDR_W-1:0] b);
    same_block = (a[ADDR_W-1:BLK_SHIFT] == b[ADDR_W-1:BLK_SHIFT]);
  endfunction : same_block

  function automatic logic [DQ_W-1:0] cmd(input logic [7:0] c);
    cmd = {8'h00, c};
  endfunction : cmd

  fcs_st_e            st_r, st_nxt;
  logic [2:0]         op_r, op_nxt;
  logic [ADDR_W-1:0]  sw_addr_r, sw_addr_nxt, cur_addr_r, cur_addr_nxt;
  logic [ADDR_W-1:0]  blk_r, blk_nxt;
  logic [DQ_W-1:0]    sw_data_r, sw_data_nxt, cur_data_r, cur_data_nxt;
  logic [DQ_W-1:0]    arr_r, arr_nxt;
  logic [7:0]         stat_r, stat_nxt;
  logic               upper_r, upper_nxt, susp_r, susp_nxt;
  logic               sreq_r, sreq_nxt, refus_r, refus_nxt;
  logic               pend_r, pend_nxt;
  logic [2:0]         pins_r, pins_nxt;
  logic [REG_DW-1:0]  rd_r, rd_nxt;

  logic               eng_req, eng_wr, eng_ready, eng_done;
  logic [DQ_W-1:0]    eng_data, eng_rdata;
  logic               ctrl_wr, legal, susp_ok;
  logic [2:0]         op_in;

  fcs_bus_cycle #(.ADDR_W(ADDR_W)) u_cycle (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .req_i     (eng_req),
    .wr_i      (eng_wr),
    .addr_i    (cur_addr_r),
    .data_i    (eng_data),
    .ready_o   (eng_ready),
    .done_o    (eng_done),
    .rdata_o   (eng_rdata),
    .ce_n_o    (ce_n_o),
    .oe_n_o    (oe_n_o),
    .we_n_o    (we_n_o),
    .addr_o    (addr_o),
    .dq_i      (dq_i),
    .dq_o      (dq_o),
    .dq_oe_o   (dq_oe_o)
  );

  // Cycle issued by each state
  always_comb begin
    eng_wr   = 1'b1;
    eng_data = cmd(CMD_READ_STATUS);
    case (st_r)
      S_CLR:    eng_data = cmd(CMD_CLEAR_STATUS);
      S_SETUP:  eng_data = (op_r == OPC_ERASE) ? cmd(CMD_ERASE_SETUP)
                                               : cmd(CMD_PROGRAM);
      S_ARG:    eng_data = (op_r == OPC_ERASE) ? cmd(CMD_CONFIRM)
                                               : cur_data_r;
      S_SUSP:   eng_data = cmd(CMD_SUSPEND);
      S_RESUME: eng_data = cmd(CMD_CONFIRM);
      S_RARR:   eng_data = cmd(CMD_READ_ARRAY);
      S_POLL, S_RDATA: eng_wr = 1'b0;
      default:  eng_data = cmd(CMD_READ_STATUS);
    endcase
  end

  assign eng_req = (st_r != S_IDLE) && eng_ready && !pend_r;
  assign ctrl_wr = reg_we_i && (reg_addr_i == REG_CTRL);
  assign op_in   = reg_wdata_i[2:0];
  assign susp_ok = (op_in == OPC_SUSPEND) && !sreq_r &&
                   (op_r == OPC_ERASE || op_r == OPC_RESUME) &&
                   (st_r == S_POLL || st_r == S_RSTAT);

  // Orders legal from idle; a suspended erase narrows them
  always_comb begin
    legal = 1'b0;
    if (st_r == S_IDLE) begin
      if (susp_r) begin
        legal = (op_in == OPC_STATUS) || (op_in == OPC_RESUME) ||
                (op_in == OPC_READ && !same_block(sw_addr_r, blk_r));
      end else begin
        legal = (op_in != OPC_RESUME) && (op_in != OPC_SUSPEND) &&
                (op_in != 3'h0);
      end
    end
  end

  always_comb begin
    st_nxt       = st_r;
    op_nxt       = op_r;
    sw_addr_nxt  = sw_addr_r;
    sw_data_nxt  = sw_data_r;
    cur_addr_nxt = cur_addr_r;
    cur_data_nxt = cur_data_r;
    blk_nxt      = blk_r;
    arr_nxt      = arr_r;
    stat_nxt     = stat_r;
    upper_nxt    = upper_r;
    susp_nxt     = susp_r;
    sreq_nxt     = sreq_r;
    refus_nxt    = refus_r;
    pins_nxt     = pins_r;
    pend_nxt     = eng_req ? 1'b1 : (eng_done ? 1'b0 : pend_r);
    if (reg_we_i) begin
      case (reg_addr_i)
        REG_ADDR: sw_addr_nxt = reg_wdata_i[ADDR_W-1:0];
        REG_DATA: sw_data_nxt = reg_wdata_i[DQ_W-1:0];
        REG_PINS: pins_nxt    = reg_wdata_i[2:0];
        default:  pins_nxt    = pins_r;
      endcase
    end
    if (ctrl_wr) begin
      refus_nxt = 1'b0;
      if (susp_ok) begin
        sreq_nxt = 1'b1;
      end else if (legal) begin
        op_nxt       = op_in;
        cur_addr_nxt = sw_addr_r;
        cur_data_nxt = sw_data_r;
        upper_nxt    = 1'b0;
        case (op_in)
          OPC_READ:    st_nxt = S_RARR;
          OPC_STATUS:  st_nxt = S_RSTAT;
          OPC_RESUME:  begin
            st_nxt       = S_RESUME;
            susp_nxt     = 1'b0;
            cur_addr_nxt = blk_r;
          end
          default:     st_nxt = S_CLR;
        endcase
        if (op_in == OPC_ERASE) begin
          blk_nxt = sw_addr_r;
        end
      end else begin
        refus_nxt = 1'b1;
      end
    end
    if (pend_r && eng_done) begin
      case (st_r)
        S_CLR:    st_nxt = (op_r == OPC_CLEAR) ? S_IDLE : S_SETUP;
        S_SETUP:  st_nxt = S_ARG;
        S_ARG, S_SUSP, S_RESUME: st_nxt = S_RSTAT;
        S_RSTAT:  st_nxt = S_POLL;
        S_POLL: begin
          stat_nxt = eng_rdata[7:0];
          if (pins_r[PIN_BYTE] && eng_rdata[DQ_W-1:8] != 8'h00) begin
            upper_nxt = 1'b1;
          end
          if (op_r == OPC_STATUS || eng_rdata[SR_READY]) begin
            st_nxt   = S_RARR;
            sreq_nxt = 1'b0;
            if (op_r != OPC_STATUS && eng_rdata[SR_SUSP]) begin
              susp_nxt = 1'b1;
            end
          end else if (sreq_r) begin
            st_nxt   = S_SUSP;
            sreq_nxt = 1'b0;
          end
        end
        S_RARR:   st_nxt = (op_r == OPC_READ) ? S_RDATA : S_IDLE;
        S_RDATA: begin
          arr_nxt = eng_rdata;
          st_nxt  = S_IDLE;
        end
        default:  st_nxt = S_IDLE;
      endcase
    end
  end

  always_comb begin
    rd_nxt = '0;
    if (reg_re_i) begin
      case (reg_addr_i)
        REG_CTRL:   rd_nxt = REG_DW'(op_r);
        REG_ADDR:   rd_nxt = REG_DW'(sw_addr_r);
        REG_DATA:   rd_nxt = REG_DW'(sw_data_r);
        REG_STATUS: rd_nxt = REG_DW'({refus_r, susp_r, st_r != S_IDLE,
                                      upper_r, stat_r});
        REG_RDATA:  rd_nxt = REG_DW'(arr_r);
        REG_PINS:   rd_nxt = REG_DW'(pins_r);
        default:    rd_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!nrst_i) begin
      st_r       <= S_IDLE;
      op_r       <= '0;
      sw_addr_r  <= '0;
      sw_data_r  <= '0;
      cur_addr_r <= '0;
      cur_data_r <= '0;
      blk_r      <= '0;
      arr_r      <= '0;
      stat_r     <= '0;
      upper_r    <= 1'b0;
      susp_r     <= 1'b0;
      sreq_r     <= 1'b0;
      refus_r    <= 1'b0;
      pend_r     <= 1'b0;
      pins_r     <= PINS_RST;
      rd_r       <= '0;
    end else begin
      st_r       <= st_nxt;
      op_r       <= op_nxt;
      sw_addr_r  <= sw_addr_nxt;
      sw_data_r  <= sw_data_nxt;
      cur_addr_r <= cur_addr_nxt;
      cur_data_r <= cur_data_nxt;
      blk_r      <= blk_nxt;
      arr_r      <= arr_nxt;
      stat_r     <= stat_nxt;
      upper_r    <= upper_nxt;
      susp_r     <= susp_nxt;
      sreq_r     <= sreq_nxt;
      refus_r    <= refus_nxt;
      pend_r     <= pend_nxt;
      pins_r     <= pins_nxt;
      rd_r       <= rd_nxt;
    end
  end

  assign reg_rdata_o = rd_r;
  assign wp_n_o      = pins_r[PIN_WP];
  assign rp_n_o      = pins_r[PIN_RP];
  assign byte_n_o    = pins_r[PIN_BYTE];

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence poll_ready_s;
    st_r == S_POLL && pend_r && eng_done && eng_rdata[SR_READY];
  endsequence
  sequence array_cmd_s;
    st_r == S_RARR && eng_req && eng_data == cmd(CMD_READ_ARRAY);
  endsequence

  chk_array_after_poll: assert property (
    poll_ready_s |=> array_cmd_s)
    else $error("no read array command after a finished poll");
  chk_clear_first: assert property (
    $rose(st_r == S_SETUP) |-> $past(st_r) == S_CLR)
    else $error("sequence started without clearing status");
  chk_clear_code: assert property (
    st_r == S_CLR && eng_req |-> eng_wr && eng_data == cmd(CMD_CLEAR_STATUS))
    else $error("clear status opcode wrong");
  chk_two_writes: assert property (
    st_r == S_SETUP && pend_r && eng_done |=> st_r == S_ARG && eng_req)
    else $error("setup not followed by the address and data write");
  chk_poll_is_read: assert property (
    (op_r == OPC_PROGRAM && st_r == S_POLL && eng_req) |-> !eng_wr)
    else $error("command written while a program runs");
  chk_busy_refuse: assert property (
    ctrl_wr && st_r != S_IDLE && !susp_ok |=> refus_r && st_r != S_IDLE)
    else $error("order taken while busy");
  chk_susp_block: assert property (
    ctrl_wr && st_r == S_IDLE && susp_r && op_in == OPC_READ &&
    same_block(sw_addr_r, blk_r) |=> st_r == S_IDLE && refus_r)
    else $error("array read of the suspended block issued");
  chk_resume_cmd: assert property (
    st_r == S_RESUME && eng_req |-> eng_wr && eng_data == cmd(CMD_CONFIRM)
      ##[1:40] !ce_n_o)
    else $error("resume not sent as a confirm write");

endmodule : fcs_host

// file: src/fcs_pkg.sv
/*
  Constants shared by the flash command host and its bus-cycle engine:
  flash opcodes, status bit positions, register offsets, operation codes
  and pin timing.
  Assumes a 250 MHz system clock and an asynchronous flash on plain pins.
*/
// Contract
// - Host writes FFH to go back to array reads; array data then follow.
// - Host toggles chip select and output enable for every status read.
// - Command 50H clears error bits; host issues it before each sequence.
// - Program is setup command then address and data write.
// - During a program the host writes no command but Read Status.
// - While suspended host issues only array read, status read or resume.
// - Host resumes with chip select low then Erase Resume; status follows.
package fcs_pkg;

  localparam int DQ_W   = 16;
  localparam int REG_AW = 8;
  localparam int REG_DW = 32;

  // Flash opcodes
  localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_PROGRAM      = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
  localparam logic [7:0] CMD_CONFIRM      = 8'hD0;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;

  // Status bit positions
  localparam int SR_READY   = 7;
  localparam int SR_SUSP    = 6;
  localparam int SR_ERA_ERR = 5;
  localparam int SR_PRG_ERR = 4;
  localparam int SR_SUP_LOW = 3;

  // Software register offsets
  localparam logic [REG_AW-1:0] REG_CTRL   = 8'h00;
  localparam logic [REG_AW-1:0] REG_ADDR   = 8'h04;
  localparam logic [REG_AW-1:0] REG_DATA   = 8'h08;
  localparam logic [REG_AW-1:0] REG_STATUS = 8'h0C;
  localparam logic [REG_AW-1:0] REG_RDATA  = 8'h10;
  localparam logic [REG_AW-1:0] REG_PINS   = 8'h14;

  // Operation codes written to the control register, bits 2..0
  localparam logic [2:0] OPC_READ    = 3'h1;
  localparam logic [2:0] OPC_STATUS  = 3'h2;
  localparam logic [2:0] OPC_CLEAR   = 3'h3;
  localparam logic [2:0] OPC_PROGRAM = 3'h4;
  localparam logic [2:0] OPC_ERASE   = 3'h5;
  localparam logic [2:0] OPC_SUSPEND = 3'h6;
  localparam logic [2:0] OPC_RESUME  = 3'h7;

  // Pin register fields and reset values
  localparam int PIN_WP   = 0;
  localparam int PIN_RP   = 1;
  localparam int PIN_BYTE = 2;
  localparam logic [2:0] PINS_RST = 3'h6;

  // Status register fields above the captured status byte
  localparam int ST_UPPER = 8;
  localparam int ST_BUSY  = 9;
  localparam int ST_SUSP  = 10;
  localparam int ST_REFUS = 11;

  // Pin timing
  localparam int CLK_NS   = 4;
  localparam int T_WE_NS  = 60;
  localparam int T_ACC_NS = 120;
  localparam int T_GAP_NS = 30;
  localparam int WE_CYC   = (T_WE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC  = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int GAP_CYC  = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W    = 8;

endpackage : fcs_pkg

// file: src/fcs_bus_cycle.sv
/*
  One flash bus cycle per request: a write pulse with data driven, or a
  read with both strobes low and the data captured at the end, followed
  by a gap with every strobe high.
  Assumes the flash data pins arrive unsynchronised.
*/
module fcs_bus_cycle #(
  parameter int ADDR_W = 17
) (
  input  wire logic                       clk_sys_i,
  input  wire logic                       nrst_i,
  input  wire logic                       req_i,
  input  wire logic                       wr_i,
  input  wire logic [ADDR_W-1:0]          addr_i,
  input  wire logic [fcs_pkg::DQ_W-1:0]   data_i,
  output logic                            ready_o,
  output logic                            done_o,
  output logic [fcs_pkg::DQ_W-1:0]        rdata_o,
  output logic                            ce_n_o,
  output logic                            oe_n_o,
  output logic                            we_n_o,
  output logic [ADDR_W-1:0]               addr_o,
  input  wire logic [fcs_pkg::DQ_W-1:0]   dq_i,
  output logic [fcs_pkg::DQ_W-1:0]        dq_o,
  output logic                            dq_oe_o
);
  import fcs_pkg::*;

  if (ACC_CYC < 3 || WE_CYC < 1 || GAP_CYC < 2 || ACC_CYC > 255) begin : g_bad
    $error("fcs_bus_cycle: pin timing cannot be served");
  end

  typedef enum logic [1:0] {BC_IDLE, BC_ACT, BC_GAP} fcs_bc_e;

  fcs_bc_e                st_r, st_nxt;
  logic [CNT_W-1:0]       cnt_r, cnt_nxt;
  logic                   wr_r, wr_nxt;
  logic [ADDR_W-1:0]      addr_r, addr_nxt;
  logic [DQ_W-1:0]        wdat_r, wdat_nxt;
  logic [DQ_W-1:0]        rdat_r, rdat_nxt;
  logic [DQ_W-1:0]        s1_r, s2_r, s3_r;
  logic                   done_r, done_nxt;

  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    wr_nxt   = wr_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    done_nxt = 1'b0;
    case (st_r)
      BC_IDLE: begin
        if (req_i) begin
          st_nxt   = BC_ACT;
          wr_nxt   = wr_i;
          addr_nxt = addr_i;
          wdat_nxt = data_i;
          cnt_nxt  = wr_i ? CNT_W'(WE_CYC - 1) : CNT_W'(ACC_CYC - 1);
        end
      end
      BC_ACT: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else if (wr_r || s2_r == s3_r) begin
          // Read data taken only once the last two sync stages agree
          if (!wr_r) begin
            rdat_nxt = s3_r;
          end
          st_nxt  = BC_GAP;
          cnt_nxt = CNT_W'(GAP_CYC - 1);
        end
      end
      BC_GAP: begin
        if (cnt_r != '0) begin
          cnt_nxt = cnt_r - 1'b1;
        end else begin
          st_nxt   = BC_IDLE;
          done_nxt = 1'b1;
        end
      end
      default: st_nxt = BC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    s1_r <= dq_i;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (!nrst_i) begin
      st_r   <= BC_IDLE;
      cnt_r  <= '0;
      wr_r   <= 1'b0;
      addr_r <= '0;
      wdat_r <= '0;
      rdat_r <= '0;
      done_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      wr_r   <= wr_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      done_r <= done_nxt;
    end
  end

  // Strobes released during the gap so each read is a fresh latch
  assign ready_o = (st_r == BC_IDLE);
  assign done_o  = done_r;
  assign rdata_o = rdat_r;
  assign addr_o  = addr_r;
  assign dq_o    = wdat_r;
  assign ce_n_o  = (st_r != BC_ACT);
  assign oe_n_o  = !(st_r == BC_ACT && !wr_r);
  assign we_n_o  = !(st_r == BC_ACT && wr_r);
  assign dq_oe_o = wr_r && (st_r != BC_IDLE);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  chk_strobe_toggle: assert property (
    $rose(oe_n_o) |-> (ce_n_o && oe_n_o) ##1 (ce_n_o && oe_n_o))
    else $error("read strobes not released between reads");

  chk_write_data_held: assert property (
    $fell(we_n_o) |-> (dq_oe_o && !ce_n_o) [*2])
    else $error("write pulse without driven data");

endmodule : fcs_bus_cycle

// file: tb/fcs_flash_model.sv
/*
  Behavioural boot-block flash: command decode, status byte, program,
  block erase, suspend and resume, boot block locking.
  Assumes fcs_host strobes; clk_i only paces the internal busy time.
*/
module fcs_flash_model #(
  parameter int AW   = 17,
  parameter int BS   = 12,
  parameter int BUSY = 200
) (
  input  wire logic          clk_i,
  input  wire logic          ce_n_i,
  input  wire logic          oe_n_i,
  input  wire logic          we_n_i,
  input  wire logic          wp_n_i,
  input  wire logic          rp_n_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [15:0]   dq_i,
  output logic      [15:0]   dq_o,
  input  wire logic          vpp_ok_i,
  input  wire logic          fail_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [2**AW];
  logic [15:0] pdat, last;
  logic [7:0]  sr = 8'h80;
  logic [7:0]  cmd = 8'hFF;
  logic [7:0]  held = 8'h80;
  bit          stat_md, susp, spend, ers;
  int          busy, blk, tgt, a;
  wire rd = !ce_n_i && !oe_n_i;
  wire wr = !ce_n_i && !we_n_i;
  initial foreach (mem[k]) mem[k] = 16'hFFFF;
  // Boot block is block 0; reset pin low locks all
  function automatic bit lockd(int x);
    return !rp_n_i || (!wp_n_i && (x >> BS) == 0);
  endfunction
  always @(posedge rd) held = sr;
  always @* if (rd) last = stat_md ? {8'h00, held} : mem[addr_i];
  // Released bus shows the inverse of the last value
  assign dq_o = rd ? last : ~last;
  always @(negedge wr) begin
    a = int'(addr_i);
    if (cmd inside {8'h40, 8'h10}) begin
      if (!vpp_ok_i) sr[3] = 1'b1;
      else if (lockd(a)) sr[4] = 1'b1;
      else begin
        busy = BUSY; tgt = a; pdat = dq_i; ers = 0; sr[7] = 1'b0;
      end
      cmd = 8'h70;
    end else if (cmd == 8'h20 && dq_i[7:0] == 8'hD0) begin
      if (!vpp_ok_i) sr = sr | 8'h28;
      else if (lockd(a)) sr[5] = 1'b1;
      else begin
        busy = 4 * BUSY; blk = a >> BS; ers = 1; sr[7] = 1'b0;
      end
      cmd = 8'h70;
    end else begin
      cmd = dq_i[7:0];
      stat_md = cmd != 8'hFF;
      if (cmd == 8'h50) sr[5:3] = 3'b000;
      if (cmd == 8'hB0 && busy > 0 && ers) spend = 1;
      if (cmd == 8'hD0 && susp) begin
        susp = 0; sr[7:6] = 2'b00;
      end
    end
  end
  always @(posedge clk_i) begin
    if (busy > 0 && !susp) begin
      if (spend) begin
        susp = 1; spend = 0; sr[7:6] = 2'b11;
      end else if (--busy == 0) begin
        sr[7] = 1'b1;
        if (fail_i) sr[ers ? 5 : 4] = 1'b1;
        else if (ers) for (int k = blk << BS; k < (blk + 1) << BS; k++)
          mem[k] = 16'hFFFF;
        else mem[tgt] = mem[tgt] & pdat;
      end
    end
  end
endmodule : fcs_flash_model

// file: tb/tb_top.sv
/*
  Self-checking bench for fcs_host against the flash model.
  Assumes the register port of fcs_host and the fcs_pkg constants.
*/
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fcs_pkg::*;
  logic clk_sys_i = 0, nrst_i = 0, reg_we = 0, reg_re = 0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v;
  logic ce_n, oe_n, we_n, dq_oe, wp_n, rp_n, byte_n, vpp_ok = 1, fail = 0;
  logic [16:0] addr, a;
  logic [15:0] hdq, mdq, d, ex;
  logic [31:0] seed = 32'h0000_001C;
  logic [15:0] sh [int];
  int fails = 0, cmp_count = 0;
  wire [15:0] bus = dq_oe ? hdq : mdq;
  fcs_host dut_u (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata), .ce_n_o(ce_n),
    .oe_n_o(oe_n), .we_n_o(we_n), .addr_o(addr), .dq_i(bus), .dq_o(hdq),
    .dq_oe_o(dq_oe), .wp_n_o(wp_n), .rp_n_o(rp_n), .byte_n_o(byte_n));
  fcs_flash_model fl_u (.clk_i(clk_sys_i), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .wp_n_i(wp_n), .rp_n_i(rp_n), .addr_i(addr),
    .dq_i(bus), .dq_o(mdq), .vpp_ok_i(vpp_ok), .fail_i(fail));
  initial forever #2 clk_sys_i = ~clk_sys_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [11:0] st_exp(bit e, bit vlow, bit bad);
    logic [7:0] s;
    s = 8'h80;
    if (vlow) s |= e ? 8'h28 : 8'h08;
    else if (bad) s |= e ? 8'h20 : 8'h10;
    return {4'h0, s};
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    @(posedge clk_sys_i);
    reg_addr <= ad; reg_wdata <= wd; reg_we <= 1'b1;
    @(posedge clk_sys_i);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad, output logic [31:0] rv);
    @(posedge clk_sys_i);
    reg_addr <= ad; reg_re <= 1'b1;
    @(posedge clk_sys_i);
    reg_re <= 1'b0;
    @(negedge clk_sys_i);
    rv = reg_rdata;
  endtask : rd
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'hFFFF_FFFF;
    for (int n = 0; n < 3000 && s[ST_BUSY] !== 1'b0; n++) rd(REG_STATUS, s);
    `CHK("idle", 1'b0, s[ST_BUSY])
  endtask : wait_idle
  task automatic op(input logic [2:0] c, input logic [16:0] ad);
    wr(REG_ADDR, {15'h0000, ad});
    wr(REG_DATA, {16'h0000, d});
    wr(REG_CTRL, {29'h0000_0000, c});
    wait_idle();
  endtask : op
  task automatic st(input logic [11:0] e);
    rd(REG_STATUS, v);
    `CHK("status", e, v[11:0])
  endtask : st
  task automatic arr(input logic [16:0] ad, input logic [15:0] e);
    op(OPC_READ, ad);
    rd(REG_RDATA, v);
    `CHK("array", e, v[15:0])
  endtask : arr
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (40000) @(posedge clk_sys_i);
    fails++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(REG_PINS, v);
    `CHK("pins", 32'h0000_0006, v)
    `CHK("pin_levels", 3'h6, {byte_n, rp_n, wp_n})
    `CHK("strobes_idle", 4'hE, {ce_n, oe_n, we_n, dq_oe})
    rd(8'h20, v);
    `CHK("unmapped", 32'h0000_0000, v)
    wr(REG_PINS, 32'h0000_0007);
    @(negedge clk_sys_i);
    `CHK("pin_levels", 3'h7, {byte_n, rp_n, wp_n})
    for (int i = 0; i < 6; i++) begin
      a = rnd(); a[12] = 1'b1; d = rnd();
      vpp_ok <= i != 2; fail <= i == 3;
      ex = sh.exists(a) ? sh[a] : 16'hFFFF;
      op(OPC_PROGRAM, a);
      st(st_exp(0, i == 2, i == 3));
      if (i != 2 && i != 3) ex &= d;
      sh[a] = ex;
      vpp_ok <= 1'b1; fail <= 1'b0;
      arr(a, ex);
    end
    op(OPC_ERASE, a);
    st(st_exp(1, 0, 0));
    arr(a, 16'hFFFF);
    wr(REG_PINS, 32'h0000_0006);
    d = 16'h1234;
    op(OPC_PROGRAM, 17'h0_0010);
    st(st_exp(0, 0, 1));
    op(OPC_ERASE, 17'h0_0010);
    st(st_exp(1, 0, 1));
    wr(REG_PINS, 32'h0000_0007);
    op(OPC_PROGRAM, 17'h0_0010);
    st(st_exp(0, 0, 0));
    vpp_ok <= 1'b0;
    op(OPC_ERASE, 17'h0_2000);
    st(st_exp(1, 1, 0));
    vpp_ok <= 1'b1; fail <= 1'b1;
    op(OPC_ERASE, 17'h0_2000);
    fail <= 1'b0;
    op(OPC_STATUS, 17'h0_0000);
    st(st_exp(1, 0, 1));
    op(OPC_CLEAR, 17'h0_0000);
    op(OPC_STATUS, 17'h0_0000);
    st(st_exp(0, 0, 0));
    wr(REG_ADDR, 32'h0000_1000);
    wr(REG_CTRL, {29'h0000_0000, OPC_ERASE});
    repeat (150) @(posedge clk_sys_i);
    wr(REG_CTRL, {29'h0000_0000, OPC_SUSPEND});
    wr(REG_CTRL, {29'h0000_0000, OPC_PROGRAM});
    wait_idle();
    st(12'hCC0);
    op(OPC_READ, 17'h0_1000);
    st(12'hCC0);
    arr(17'h0_0010, 16'h1234);
    op(OPC_RESUME, 17'h0_0000);
    st(st_exp(1, 0, 0));
    arr(17'h0_1000, 16'hFFFF);
    op(OPC_RESUME, 17'h0_0000);
    st(12'h880);
    tally_and_finish();
  end
endmodule : tb_top
